// File: rtl/dtt_timer.sv
// Definite-time trip timer: pickup, delay counting, trip, test and target.
// Assumes the analog comparator, range and tap selection sit outside and
// deliver one threshold-exceeded level; all panel inputs are asynchronous,
// and the delay digits pass the same three-stage filter as one word.
// Functional notes
// - When the threshold input is high, the pickup lamp turns on and the delay interval starts.
// - The delay comes from two front-panel digits spanning 0.0 to 9.9 s in 0.1 s steps.
// - A delay selection of 00 trips with no deliberate delay.
// - Dropping below pickup before timeout clears the count, so timing restarts from zero.
// - The delay is counted from a calibrated tick and compared to the delay selection.
// - Pickup level is set by the ten-position tap and the high/low range, outside this block.
// - A range change under current needs no reset; the timer just follows the threshold level.
// - Total response is the averaging settle time outside plus the counted delay here.
// - On timeout with the threshold still high, the trip output and auxiliary output energize.
// - The test button energizes the output relays directly, regardless of timing.
// - The target latches once trip has energized and holds until a manual reset.
`timescale 1ns/1ns
`include "dtt_defines.svh"
`default_nettype none

module dtt_timer
  import dtt_pkg::*;
#(
  parameter int TICK_CYCLES = `DTT_TICK_CYCLES
) (
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       reset_n,
  // Panel and comparator
  input  wire dtt_panel_s panel,
  input  wire dtt_delay_s delay_sel,
  // Outputs to lamps and relay drivers
  output logic            pickup_lamp,
  output logic            trip_out,
  output logic            aux_out,
  output logic            target_flag
);

  // Three-stage synchronisers; first stage only feeds the second
  logic [2:0] sync_a, sync_b, sync_c;
  logic [2:0] next_sync_a, next_sync_b, next_sync_c;
  logic [2:0] clean, next_clean;

  always_comb begin
    next_sync_a = {panel.over_pickup, panel.test_button, panel.target_reset};
    next_sync_b = sync_a;
    next_sync_c = sync_b;
    next_clean  = clean;
    for (int i = 0; i < 3; i++) begin
      if (sync_b[i] == sync_c[i]) begin
        next_clean[i] = sync_c[i];
      end
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      sync_a <= `DTT_SYNC_RESET;
      sync_b <= `DTT_SYNC_RESET;
      sync_c <= `DTT_SYNC_RESET;
      clean  <= `DTT_SYNC_RESET;
    end else begin
      sync_a <= next_sync_a;
      sync_b <= next_sync_b;
      sync_c <= next_sync_c;
      clean  <= next_clean;
    end
  end

  // Thumbwheel digits are pins as well; the word is taken only when both late
  // stages agree, so a switch caught between detents never reaches the compare
  dtt_delay_s dsel_a, dsel_b, dsel_c, dsel_clean;
  dtt_delay_s next_dsel_a, next_dsel_b, next_dsel_c, next_dsel_clean;

  always_comb begin
    next_dsel_a     = delay_sel;
    next_dsel_b     = dsel_a;
    next_dsel_c     = dsel_b;
    next_dsel_clean = dsel_clean;
    if (dsel_b == dsel_c) begin
      next_dsel_clean = dsel_c;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      dsel_a     <= `DTT_DELAY_RESET;
      dsel_b     <= `DTT_DELAY_RESET;
      dsel_c     <= `DTT_DELAY_RESET;
      dsel_clean <= `DTT_DELAY_RESET;
    end else begin
      dsel_a     <= next_dsel_a;
      dsel_b     <= next_dsel_b;
      dsel_c     <= next_dsel_c;
      dsel_clean <= next_dsel_clean;
    end
  end

  logic over, test_btn, tgt_rst;
  // The filtered level is all this block sees of tap, range and averaging
  assign over     = clean[2];
  assign test_btn = clean[1];
  assign tgt_rst  = clean[0];

  // Out-of-range digits are clamped to 9 so a bad switch never disables timing
  function automatic logic [3:0] clamp_digit(input logic [3:0] d);
    clamp_digit = (d > `DTT_DIGIT_MAX) ? `DTT_DIGIT_MAX : d;
  endfunction : clamp_digit

  function automatic dtt_count_t bcd_to_ticks(input dtt_delay_s d);
    logic [3:0] u;
    logic [3:0] t;
    u = clamp_digit(d.units);
    t = clamp_digit(d.tenths);
    bcd_to_ticks = 7'((u * 10) + t);
  endfunction : bcd_to_ticks

  dtt_state_e state, next_state;
  dtt_tick_t  prescale, next_prescale;
  dtt_count_t tenths, next_tenths;
  dtt_count_t target_ticks;
  logic       tick;

  assign target_ticks = bcd_to_ticks(dsel_clean);

  // Prescaler rests at zero outside an unfinished interval
  // Compare runs before the next tick, so trip lands three clocks after the last one
  always_comb begin
    tick          = 1'b0;
    next_prescale = '0;
    if ((state == DTT_TIMING) && over && (tenths < target_ticks)) begin
      if (prescale == 20'(TICK_CYCLES - 1)) begin
        tick = 1'b1;
      end else begin
        next_prescale = prescale + 20'h0_0001;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      prescale <= '0;
    end else begin
      prescale <= next_prescale;
    end
  end

  // Timing state and tenth count
  always_comb begin
    next_state  = state;
    next_tenths = tenths;
    case (state)
      DTT_IDLE: begin
        next_tenths = '0;
        if (over) begin
          // Zero setting skips the timing state entirely
          next_state = (target_ticks == '0) ? DTT_TRIPPED : DTT_TIMING;
        end
      end
      DTT_TIMING: begin
        if (!over) begin
          next_state = DTT_IDLE;
        end else if (tenths >= target_ticks) begin
          next_state = DTT_TRIPPED;
        end else if (tick) begin
          next_tenths = tenths + 7'h01;
        end
      end
      DTT_TRIPPED: begin
        if (!over) begin
          next_state = DTT_IDLE;
        end
      end
      default: begin
        next_state = DTT_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state  <= DTT_IDLE;
      tenths <= '0;
    end else begin
      state  <= next_state;
      tenths <= next_tenths;
    end
  end

  // Lamp and relay drives come straight from flops
  logic next_pickup, next_trip, next_aux, next_target;
  logic relay_on;

  always_comb begin
    relay_on    = (state == DTT_TRIPPED);
    // Range or tap changes only move the comparator; no restart needed
    next_pickup = over;
    // Test path skips the timer so relay wiring can be proven
    next_trip   = relay_on || test_btn;
    next_aux    = relay_on || test_btn;
    // Set wins over a simultaneous manual reset
    next_target = next_trip || (target_flag && !tgt_rst);
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      pickup_lamp <= 1'b0;
      trip_out    <= 1'b0;
      aux_out     <= 1'b0;
      target_flag <= 1'b0;
    end else begin
      pickup_lamp <= next_pickup;
      trip_out    <= next_trip;
      aux_out     <= next_aux;
      target_flag <= next_target;
    end
  end

endmodule : dtt_timer

`default_nettype wire

// File: rtl/dtt_defines.svh
// Timing constants and reset values for the definite-time trip timer.
// Assumes sys_clk at 10 MHz; included by its bare name.
`ifndef DTT_DEFINES_SVH
`define DTT_DEFINES_SVH
`define DTT_CLK_HZ        10_000_000
`define DTT_TICK_MS       100
`define DTT_TICK_CYCLES   ((`DTT_CLK_HZ / 1000) * `DTT_TICK_MS)
`define DTT_DIGIT_MAX     4'h9
`define DTT_SYNC_RESET    3'h0
`define DTT_DELAY_RESET   8'h99
`endif

// File: rtl/dtt_pkg.sv
// Types for the definite-time trip timer.
// Assumes dtt_defines.svh is available on the include path.
`default_nettype none
package dtt_pkg;
  typedef enum logic [1:0] {
    DTT_IDLE,
    DTT_TIMING,
    DTT_TRIPPED
  } dtt_state_e;

  // Front-panel delay selection, two decimal digits
  typedef struct packed {
    logic [3:0] units;
    logic [3:0] tenths;
  } dtt_delay_s;

  // Panel inputs: the comparator threshold level plus the test and target-reset buttons
  typedef struct packed {
    logic       over_pickup;
    logic       test_button;
    logic       target_reset;
  } dtt_panel_s;

  typedef logic [6:0]  dtt_count_t;
  typedef logic [19:0] dtt_tick_t;
endpackage : dtt_pkg
`default_nettype wire

// File: dv/dtt_comp.sv
// Comparator model: averaged var level against the pickup reference.
// Assumes the bench sets level and reference; output is a plain level.
`timescale 1ns/1ns
`default_nettype none
module dtt_comp (
  // Analog side
  input  wire logic [7:0] level,
  input  wire logic [7:0] ref_lvl,
  // To the timer
  output logic            over
);
  assign over = level > ref_lvl;
endmodule : dtt_comp
`default_nettype wire

// File: dv/dtt_timer_asserts.sv
// Checker for the trip timer port relations.
// Assumes a bind onto dtt_timer; panel levels held several cycles.
`timescale 1ns/1ns
`default_nettype none
module dtt_timer_asserts
  import dtt_pkg::*;
(
  // Watched ports
  input wire logic       sys_clk,
  input wire logic       reset_n,
  input wire dtt_panel_s panel,
  input wire dtt_delay_s delay_sel,
  input wire logic       pickup_lamp,
  input wire logic       trip_out,
  input wire logic       aux_out,
  input wire logic       target_flag
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  AST_AUX: assert property (aux_out == trip_out) else $error("aux");
  AST_LAMP: assert property (panel.over_pickup[*7] |-> pickup_lamp) else $error("lamp");
  AST_DROP: assert property ((!panel.over_pickup && !panel.test_button)[*7] |-> !trip_out)
    else $error("drop");
  AST_TEST: assert property (panel.test_button[*7] |-> trip_out) else $error("test");
  AST_NOW: assert property ((panel.over_pickup && delay_sel == 8'h00)[*8] |-> trip_out)
    else $error("now");
  AST_WAIT: assert property ($rose(pickup_lamp) && delay_sel != 8'h00 && !panel.test_button
    |-> !trip_out[*4]) else $error("early");
  AST_TGT: assert property ($rose(trip_out) |=> target_flag) else $error("tgt");
  AST_HOLD: assert property ((!panel.target_reset)[*6] ##0 target_flag |=> target_flag)
    else $error("hold");
  cover property ($rose(trip_out));
  cover property ($fell(target_flag));
  cover property (panel.test_button && trip_out);
endmodule : dtt_timer_asserts
`default_nettype wire

// File: dv/dtt_timer_bench.sv
// Bench for the trip timer with a comparator model on its input.
// Assumes TICK_CYCLES of 4 so each tenth is four clocks.
`timescale 1ns/1ns
`default_nettype none
module dtt_timer_bench
  import dtt_pkg::*;
;
  localparam int T = 4;
  logic sys_clk = 0, reset_n = 0, over, btn = 0, trst = 0, pl, tr, ax, tg;
  logic [7:0] lvl = 8'h10;
  logic [7:0] rl = 8'h40;
  dtt_delay_s dsel = 8'h00;
  dtt_panel_s panel;
  int n_fail = 0, n_checks = 0;
  assign panel = {over, btn, trst};
  dtt_comp i_dtt_comp (.level(lvl), .ref_lvl(rl), .over(over));
  dtt_timer #(.TICK_CYCLES(T)) i_dtt_timer (.sys_clk(sys_clk), .reset_n(reset_n),
    .panel(panel), .delay_sel(dsel), .pickup_lamp(pl), .trip_out(tr), .aux_out(ax),
    .target_flag(tg));
  initial forever #50 sys_clk = ~sys_clk;
  task cyc(input int k);
    repeat (k) @(posedge sys_clk);
    #5;
  endtask : cyc
  task check(input logic g, input logic e);
    n_checks++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH t=%0t got %b expected %b", $time, g, e);
    end
  endtask : check
  task results;
    $display("checks %0d fails %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : results
  // Expected clocks from pickup to trip, digits above 9 taken as 9
  function automatic int exp_ticks(input dtt_delay_s d);
    int u, t;
    u = (d.units > 4'h9) ? 9 : int'(d.units);
    t = (d.tenths > 4'h9) ? 9 : int'(d.tenths);
    return (u * 10 + t) * T;
  endfunction : exp_ticks
  // Glitch first exercises the clear-on-drop path
  task run(input dtt_delay_s d, input bit gl);
    int c, n;
    dsel = d;
    n = exp_ticks(d);
    if (gl) begin
      lvl = 8'hC0;
      cyc(12);
      check(tr, 1'b0);
      lvl = 8'h10;
      cyc(8);
    end
    lvl = 8'h41 + 8'($urandom_range(0, 190));
    c = 0;
    while (!pl && c < 20) begin cyc(1); c++; end
    check(pl, 1'b1);
    // Range switch moved under current; level stays above the new reference
    rl = 8'h20 + 8'($urandom_range(0, 31));
    c = 0;
    while (!tr && c < 500) begin cyc(1); c++; end
    check(c >= n && c <= n + 8, 1'b1);
    check(ax, 1'b1);
    lvl = 8'h10;
    cyc(8);
    check(tr, 1'b0);
    check(tg, 1'b1);
    trst = 1;
    cyc(8);
    trst = 0;
    check(tg, 1'b0);
    $display("end test delay %h", d);
  endtask : run
  initial begin
    void'($urandom(45));
    cyc(6);
    reset_n = 1;
    run(8'h00, 0);
    run(8'h99, 0);
    run(8'h05, 1);
    run(8'h02, 0);
    run(8'h0F, 0);
    repeat (3) run({4'($urandom_range(0, 1)), 4'($urandom_range(0, 9))}, 0);
    // Reset in mid-interval must leave nothing behind for the next pickup
    dsel = 8'h10;
    lvl = 8'hC0;
    cyc(30);
    reset_n = 0;
    cyc(1);
    check(pl, 1'b0);
    reset_n = 1;
    run(8'h10, 0);
    btn = 1;
    cyc(8);
    check(tr, 1'b1);
    btn = 0;
    cyc(8);
    check(tr, 1'b0);
    $display("end test button");
    results();
  end
  initial begin
    cyc(8000);
    n_fail++;
    results();
  end
endmodule : dtt_timer_bench
bind dtt_timer dtt_timer_asserts i_dtt_timer_asserts (.sys_clk(sys_clk), .reset_n(reset_n),
  .panel(panel), .delay_sel(delay_sel), .pickup_lamp(pickup_lamp), .trip_out(trip_out),
  .aux_out(aux_out), .target_flag(target_flag));
`default_nettype wire
